// >>> byte_exec_pkg.sv
// Constants, types and register map for the byte-operation execution block
//
// Overview of operation
// - Increment file, result to accumulator or file
// - OR accumulator with file, route by destination
// - Copy file to accumulator or back to itself
// - Copy, increment, OR update the zero flag
// - Load literal into accumulator, flags untouched
// - Store accumulator into file, flags untouched
// - Return literal: load accumulator, pop stack to counter
// - Return literal takes two instruction cycles
// - Interrupt return pops counter, sets global enable
// - Rotate left through carry, route by destination
package byte_exec_pkg;

    localparam int DATA_W   = 8;
    localparam int FADDR_W  = 7;
    localparam int FILES    = 128;
    localparam int INSTR_W  = 14;
    localparam int PC_W     = 13;
    localparam int AXI_AW   = 12;
    localparam int AXI_DW   = 32;
    localparam int STRB_W   = 4;
    localparam int STACK_N  = 8;

    // Register byte offsets
    localparam logic [AXI_AW-1:0] REG_INSTR  = 12'h000;
    localparam logic [AXI_AW-1:0] REG_ACCUM  = 12'h004;
    localparam logic [AXI_AW-1:0] REG_STATUS = 12'h008;
    localparam logic [AXI_AW-1:0] REG_PC     = 12'h00C;
    localparam logic [AXI_AW-1:0] REG_STACK  = 12'h010;
    localparam logic [2:0]        FILE_WIN   = 3'h1;
    localparam int                WIN_LSB    = 9;
    localparam int                IDX_LSB    = 2;

    // Status register fields
    localparam int ZERO_BIT  = 0;
    localparam int CARRY_BIT = 1;
    localparam int IRQ_EN_BIT = 2;
    localparam int BUSY_BIT  = 3;

    // Instruction fields and encodings
    localparam int DEST_BIT = 7;
    localparam logic [5:0] OPC_OR_FILE  = 6'h04;
    localparam logic [5:0] OPC_COPY     = 6'h08;
    localparam logic [5:0] OPC_INC      = 6'h0A;
    localparam logic [5:0] OPC_ROT_L    = 6'h0D;
    localparam logic [6:0] OPC_STORE    = 7'h01;
    localparam logic [3:0] OPC_LOAD_LIT = 4'hC;
    localparam logic [3:0] OPC_RET_LIT  = 4'hD;
    localparam logic [INSTR_W-1:0] OPC_IRQ_RET = 14'h0009;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST    = 13'h0000;
    localparam logic [PC_W-1:0]   PC_STEP   = 13'h0001;

    typedef enum logic [3:0] {
        OP_NONE, OP_INC, OP_OR, OP_COPY, OP_ROT_L,
        OP_LOAD_LIT, OP_STORE, OP_RET_LIT, OP_IRQ_RET
    } op_e;

    // Gray codes along idle -> execute -> second cycle
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_EXEC   = 2'b01,
        ST_SECOND = 2'b11
    } exec_state_e;

endpackage

// >>> byte_exec_units.sv
// Byte ALU and return-address stack used by the execution block
`timescale 1ns/1ps
`default_nettype none

module byte_alu
    import byte_exec_pkg::*;
(
    input  wire op_e               op,
    input  wire logic [DATA_W-1:0] accum,
    input  wire logic [DATA_W-1:0] fval,
    input  wire logic              carry_in,
    output logic      [DATA_W-1:0] result,
    output logic                   carry_out
);
    always_comb begin
        result    = fval;
        carry_out = carry_in;
        unique case (op)
            OP_INC:   result = fval + 8'h01;
            OP_OR:    result = accum | fval;
            OP_COPY:  result = fval;
            OP_ROT_L: begin
                result    = {fval[DATA_W-2:0], carry_in};
                carry_out = fval[DATA_W-1];
            end
            default:  result = fval;
        endcase
    end
endmodule

module return_stack
    import byte_exec_pkg::*;
#(
    parameter int DEPTH = STACK_N
)
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            push,
    input  wire logic [PC_W-1:0] push_val,
    input  wire logic            pop,
    output logic      [PC_W-1:0] top
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][PC_W-1:0] slot;
        logic [PW-1:0]              ptr;
    } stack_s;

    stack_s st;
    stack_s next_st;

    // Circular: overflow overwrites the oldest entry
    always_comb begin
        next_st = st;
        if (pop) begin
            next_st.ptr = st.ptr - 1'b1;
        end else if (push) begin
            next_st.ptr = st.ptr + 1'b1;
            next_st.slot[PW'(st.ptr + 1'b1)] = push_val;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign top = st.slot[st.ptr];
endmodule

`default_nettype wire

// >>> byte_exec_core.sv
// Byte-operation execution unit with file registers, reached over AXI4-Lite
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module byte_exec_core
    import byte_exec_pkg::*;
(
    input  wire logic              SYS_CLK,
    input  wire logic              RESET,
    input  wire logic [AXI_AW-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [AXI_DW-1:0] S_AXI_WDATA,
    input  wire logic [STRB_W-1:0] S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic      [1:0]        S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [AXI_AW-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic      [AXI_DW-1:0] S_AXI_RDATA,
    output logic      [1:0]        S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    output logic                   BUSY
);

    typedef struct packed {
        exec_state_e                 state;
        logic [INSTR_W-1:0]          instr;
        logic [DATA_W-1:0]           accum;
        logic                        zero;
        logic                        carry;
        logic                        irq_en;
        logic [PC_W-1:0]             pc;
        logic [FILES-1:0][DATA_W-1:0] files;
        logic                        aw_held;
        logic [AXI_AW-1:0]           awaddr;
        logic                        w_held;
        logic [AXI_DW-1:0]           wdata;
        logic [STRB_W-1:0]           wstrb;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [AXI_DW-1:0]           rdata;
        logic [1:0]                  rresp;
    } core_s;

    core_s st;
    core_s next_st;

    op_e               op;
    logic              dest_file;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0] literal;
    logic [DATA_W-1:0] fval;
    logic [DATA_W-1:0] alu_result;
    logic              alu_carry;
    logic [PC_W-1:0]   stack_top;
    logic              stack_push;
    logic              stack_pop;
    logic              wr_fire;
    logic [AXI_DW-1:0] wr_merged;
    logic [AXI_DW-1:0] rd_value;
    logic              rd_ok;
    logic              wr_ok;

    // Instruction decode
    always_comb begin
        op = OP_NONE;
        if (st.instr == OPC_IRQ_RET) begin
            op = OP_IRQ_RET;
        end else if (st.instr[INSTR_W-1 -: $bits(OPC_STORE)] == OPC_STORE) begin
            op = OP_STORE;
        end else if (st.instr[INSTR_W-1 -: $bits(OPC_LOAD_LIT)] == OPC_LOAD_LIT) begin
            op = OP_LOAD_LIT;
        end else if (st.instr[INSTR_W-1 -: $bits(OPC_RET_LIT)] == OPC_RET_LIT) begin
            op = OP_RET_LIT;
        end else begin
            unique case (st.instr[INSTR_W-1 -: $bits(OPC_INC)])
                OPC_INC:     op = OP_INC;
                OPC_OR_FILE: op = OP_OR;
                OPC_COPY:    op = OP_COPY;
                OPC_ROT_L:   op = OP_ROT_L;
                default:     op = OP_NONE;
            endcase
        end
    end

    assign dest_file = st.instr[DEST_BIT];
    assign faddr     = st.instr[FADDR_W-1:0];
    assign literal   = st.instr[DATA_W-1:0];
    assign fval      = st.files[faddr];

    byte_alu u_alu (
        .op        (op),
        .accum     (st.accum),
        .fval      (fval),
        .carry_in  (st.carry),
        .result    (alu_result),
        .carry_out (alu_carry)
    );

    return_stack #(
        .DEPTH (STACK_N)
    ) u_stack (
        .clk      (SYS_CLK),
        .rst      (RESET),
        .push     (stack_push),
        .push_val (wr_merged[PC_W-1:0]),
        .pop      (stack_pop),
        .top      (stack_top)
    );

    // Byte-lane merge of a bus write onto the old register value
    function automatic logic [AXI_DW-1:0] merge(
        input logic [AXI_DW-1:0] old,
        input logic [AXI_DW-1:0] data,
        input logic [STRB_W-1:0] strb
    );
        logic [AXI_DW-1:0] res;
        res = old;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic is_file(input logic [AXI_AW-1:0] a);
        return a[AXI_AW-1:WIN_LSB] == FILE_WIN;
    endfunction

    function automatic logic [FADDR_W-1:0] file_idx(input logic [AXI_AW-1:0] a);
        return a[IDX_LSB +: FADDR_W];
    endfunction

    // Read mux
    always_comb begin
        rd_value = '0;
        rd_ok    = 1'b1;
        if (is_file(S_AXI_ARADDR)) begin
            rd_value[DATA_W-1:0] = st.files[file_idx(S_AXI_ARADDR)];
        end else begin
            unique case (S_AXI_ARADDR)
                REG_INSTR:  rd_value[INSTR_W-1:0] = st.instr;
                REG_ACCUM:  rd_value[DATA_W-1:0]  = st.accum;
                REG_STATUS: begin
                    rd_value[ZERO_BIT]  = st.zero;
                    rd_value[CARRY_BIT] = st.carry;
                    rd_value[IRQ_EN_BIT] = st.irq_en;
                    rd_value[BUSY_BIT]  = st.state != ST_IDLE;
                end
                REG_PC:     rd_value[PC_W-1:0] = st.pc;
                REG_STACK:  rd_value[PC_W-1:0] = stack_top;
                default:    rd_ok = 1'b0;
            endcase
        end
    end

    assign wr_fire = st.aw_held && st.w_held && !st.bvalid;

    // Old value under the held write address, for lane merging
    always_comb begin
        wr_merged = '0;
        wr_ok     = 1'b1;
        if (is_file(st.awaddr)) begin
            wr_merged[DATA_W-1:0] = st.files[file_idx(st.awaddr)];
        end else begin
            unique case (st.awaddr)
                REG_INSTR:  wr_merged[INSTR_W-1:0] = st.instr;
                REG_ACCUM:  wr_merged[DATA_W-1:0]  = st.accum;
                REG_STATUS: begin
                    wr_merged[ZERO_BIT]  = st.zero;
                    wr_merged[CARRY_BIT] = st.carry;
                    wr_merged[IRQ_EN_BIT] = st.irq_en;
                end
                REG_PC:     wr_merged[PC_W-1:0] = st.pc;
                REG_STACK:  wr_merged[PC_W-1:0] = stack_top;
                default:    wr_ok = 1'b0;
            endcase
        end
        wr_merged = merge(wr_merged, st.wdata, st.wstrb);
    end

    // Pushes are refused while an instruction is in flight
    assign stack_push = wr_fire && wr_ok && st.awaddr == REG_STACK && st.state == ST_IDLE;
    assign stack_pop  = st.state == ST_SECOND;

    always_comb begin
        next_st = st;

        // Address and data channels are taken independently
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr  = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_st.w_held = 1'b1;
            next_st.wdata  = S_AXI_WDATA;
            next_st.wstrb  = S_AXI_WSTRB;
        end
        if (st.bvalid && S_AXI_BREADY) begin
            next_st.bvalid = 1'b0;
        end

        if (wr_fire) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (is_file(st.awaddr)) begin
                next_st.files[file_idx(st.awaddr)] = wr_merged[DATA_W-1:0];
            end else begin
                unique case (st.awaddr)
                    REG_INSTR: begin
                        if (st.state == ST_IDLE) begin
                            next_st.instr = wr_merged[INSTR_W-1:0];
                            next_st.state = ST_EXEC;
                        end
                    end
                    REG_ACCUM:  next_st.accum = wr_merged[DATA_W-1:0];
                    REG_STATUS: begin
                        next_st.zero  = wr_merged[ZERO_BIT];
                        next_st.carry = wr_merged[CARRY_BIT];
                        next_st.irq_en = wr_merged[IRQ_EN_BIT];
                    end
                    REG_PC:     next_st.pc = wr_merged[PC_W-1:0];
                    default:    next_st.pc = st.pc;
                endcase
            end
        end

        // Read channel: one outstanding read
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = rd_value;
            next_st.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (st.rvalid && S_AXI_RREADY) begin
            next_st.rvalid = 1'b0;
        end

        // Execution overrides a bus write landing in the same cycle
        unique case (st.state)
            ST_IDLE: begin
            end
            ST_EXEC: begin
                next_st.state = ST_IDLE;
                next_st.pc    = st.pc + PC_STEP;
                unique case (op)
                    OP_INC, OP_OR, OP_COPY: begin
                        if (dest_file) begin
                            next_st.files[faddr] = alu_result;
                        end else begin
                            next_st.accum = alu_result;
                        end
                        next_st.zero = alu_result == '0;
                    end
                    OP_ROT_L: begin
                        if (dest_file) begin
                            next_st.files[faddr] = alu_result;
                        end else begin
                            next_st.accum = alu_result;
                        end
                        next_st.carry = alu_carry;
                    end
                    OP_LOAD_LIT: next_st.accum = literal;
                    OP_STORE:    next_st.files[faddr] = st.accum;
                    OP_RET_LIT: begin
                        next_st.accum = literal;
                        next_st.state = ST_SECOND;
                    end
                    OP_IRQ_RET: begin
                        next_st.irq_en = 1'b1;
                        next_st.state = ST_SECOND;
                    end
                    default: begin
                    end
                endcase
            end
            ST_SECOND: begin
                next_st.pc    = stack_top;
                next_st.state = ST_IDLE;
            end
            default: next_st.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st       <= '0;
            st.state <= ST_IDLE;
            st.accum <= ACCUM_RST;
            st.pc    <= PC_RST;
        end else begin
            st <= next_st;
        end
    end

    assign S_AXI_AWREADY = !st.aw_held && !st.bvalid;
    assign S_AXI_WREADY  = !st.w_held && !st.bvalid;
    assign S_AXI_BVALID  = st.bvalid;
    assign S_AXI_BRESP   = st.bresp;
    assign S_AXI_ARREADY = !st.rvalid;
    assign S_AXI_RVALID  = st.rvalid;
    assign S_AXI_RDATA   = st.rdata;
    assign S_AXI_RRESP   = st.rresp;
    assign BUSY          = st.state != ST_IDLE;

endmodule

`default_nettype wire

// >>> byte_exec_core_chk.sv
// Bus and execution timing checker for the byte-operation execution block
`timescale 1ns/1ps
`default_nettype none

module byte_exec_core_chk
    import byte_exec_pkg::*;
(
    input wire logic              SYS_CLK,
    input wire logic              RESET,
    input wire logic              S_AXI_AWVALID,
    input wire logic              S_AXI_AWREADY,
    input wire logic              S_AXI_WVALID,
    input wire logic              S_AXI_WREADY,
    input wire logic [1:0]        S_AXI_BRESP,
    input wire logic              S_AXI_BVALID,
    input wire logic              S_AXI_BREADY,
    input wire logic              S_AXI_ARVALID,
    input wire logic              S_AXI_ARREADY,
    input wire logic [AXI_DW-1:0] S_AXI_RDATA,
    input wire logic [1:0]        S_AXI_RRESP,
    input wire logic              S_AXI_RVALID,
    input wire logic              S_AXI_RREADY,
    input wire logic              BUSY
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    property p_b_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped or changed");

    property p_r_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped or changed");

    property p_ar_block;
        S_AXI_RVALID |-> !S_AXI_ARREADY;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read address accepted while data pending");

    property p_r_answer;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");

    // Address and data taken together: response two edges later
    property p_b_answer;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_BVALID ##1 S_AXI_BVALID;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("write answer timing wrong");

    property p_w_block;
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write accepted while response pending");

    property p_err_zero;
        S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == '0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read returned data");

    property p_busy_len;
        $rose(BUSY) |-> ##[1:2] !BUSY;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("instruction ran too long");

    property p_busy_start;
        $rose(BUSY) |-> $rose(S_AXI_BVALID);
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("execution began without a write");
endmodule

bind byte_exec_core byte_exec_core_chk chk (.SYS_CLK, .RESET, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .BUSY);

`default_nettype wire

// >>> byte_op_instruction_exec_test.sv
// Self-checking testbench for the byte-operation execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module byte_op_instruction_exec_test
    import byte_exec_pkg::*;
;
    logic              SYS_CLK       = 1'b0;
    logic              RESET         = 1'b1;
    logic [AXI_AW-1:0] S_AXI_AWADDR  = '0;
    logic [AXI_AW-1:0] S_AXI_ARADDR  = '0;
    logic [AXI_DW-1:0] S_AXI_WDATA   = '0;
    logic [STRB_W-1:0] S_AXI_WSTRB   = '0;
    logic              S_AXI_AWVALID = 1'b0;
    logic              S_AXI_WVALID  = 1'b0;
    logic              S_AXI_BREADY  = 1'b0;
    logic              S_AXI_ARVALID = 1'b0;
    logic              S_AXI_RREADY  = 1'b0;
    logic              S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, BUSY;
    logic [1:0]        S_AXI_BRESP, S_AXI_RRESP;
    logic [AXI_DW-1:0] S_AXI_RDATA;
    int                n_errors      = 0;
    int                num_checks    = 0;
    integer            seed          = 35485;
    logic [31:0]       rv;
    logic [1:0]        eb[$];
    logic [33:0]       er[$];
    logic [1:0]        ex_b;
    logic [33:0]       ex_r;
    logic [7:0]        m_acc;
    logic [7:0]        m_f[FILES];
    logic              m_z, m_c, m_irq_en;
    logic [PC_W-1:0]   m_pc;
    logic [PC_W-1:0]   stk[STACK_N];
    logic [2:0]        sp;
    op_e               o;

    byte_exec_core uut (.SYS_CLK, .RESET, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
        .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
        .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .BUSY);

    always #5 SYS_CLK = ~SYS_CLK;

    // Response watcher: compares each answer with the oldest note
    always @(posedge SYS_CLK) begin
        if (S_AXI_BVALID && S_AXI_BREADY) begin
            ex_b = eb.pop_front();
            `CHK("bresp", ex_b, S_AXI_BRESP)
        end
        if (S_AXI_RVALID && S_AXI_RREADY) begin
            ex_r = er.pop_front();
            `CHK("rdata", ex_r[31:0], S_AXI_RDATA)
            `CHK("rresp", ex_r[33:32], S_AXI_RRESP)
        end
    end

    function automatic logic [AXI_AW-1:0] fa(input logic [6:0] f);
        return {FILE_WIN, f, 2'b00};
    endfunction

    // bw / rw: edge count before the answer is accepted, 0 for at once
    task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY,
                      input int bw = 0, input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        eb.push_back(r);
        @(posedge SYS_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= (bw == 0);
        do begin
            @(posedge SYS_CLK);
            n++;
            if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (n == bw) S_AXI_BREADY <= 1'b1;
        end while (!(S_AXI_BVALID === 1'b1 && S_AXI_BREADY === 1'b1));
        S_AXI_BREADY <= 1'b0;
    endtask

    task automatic rd(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY,
                      input int rw = 0);
        int n;
        n = 0;
        er.push_back({r, d});
        @(posedge SYS_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= (rw == 0);
        do begin
            @(posedge SYS_CLK);
            n++;
            if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            if (n == rw) S_AXI_RREADY <= 1'b1;
        end while (!(S_AXI_RVALID === 1'b1 && S_AXI_RREADY === 1'b1));
        S_AXI_RREADY <= 1'b0;
    endtask

    task automatic chk_all(input logic [6:0] f);
        rd(REG_ACCUM, {24'h0, m_acc});
        rd(REG_STATUS, {28'h0, 1'b0, m_irq_en, m_c, m_z});
        rd(REG_PC, {19'h0, m_pc});
        rd(fa(f), {24'h0, m_f[f]});
    endtask

    task automatic push(input logic [PC_W-1:0] v);
        wr(REG_STACK, 32'(v));
        stk[sp] = v;
        sp = sp + 3'd1;
        rd(REG_STACK, 32'(v));
    endtask

    // Runs one instruction, updates the reference state and reads back accumulator, status, counter, file f and instruction
    task automatic op(input op_e p, input logic d, input logic [6:0] f, input logic [7:0] k);
        logic [INSTR_W-1:0] i;
        logic [7:0]         fv;
        logic [7:0]         r;
        int                 n;
        n = 0;
        fv = m_f[f];
        r = fv;
        case (p)
            OP_INC: begin
                i = {OPC_INC, d, f};
                r = fv + 8'h01;
            end
            OP_OR: begin
                i = {OPC_OR_FILE, d, f};
                r = m_acc | fv;
            end
            OP_COPY: i = {OPC_COPY, d, f};
            OP_ROT_L: begin
                i = {OPC_ROT_L, d, f};
                r = {fv[6:0], m_c};
                m_c = fv[7];
            end
            OP_LOAD_LIT: begin
                i = {OPC_LOAD_LIT, 2'b00, k};
                m_acc = k;
            end
            OP_STORE: begin
                i = {OPC_STORE, f};
                m_f[f] = m_acc;
            end
            OP_RET_LIT: begin
                i = {OPC_RET_LIT, 2'b00, k};
                m_acc = k;
            end
            OP_NONE: i = '0;
            default: begin
                i = OPC_IRQ_RET;
                m_irq_en = 1'b1;
            end
        endcase
        if (p inside {OP_INC, OP_OR, OP_COPY}) m_z = (r == 8'h00);
        if (p inside {OP_INC, OP_OR, OP_COPY, OP_ROT_L}) begin
            if (d) m_f[f] = r;
            else m_acc = r;
        end
        if (p inside {OP_RET_LIT, OP_IRQ_RET}) begin
            sp = sp - 3'd1;
            m_pc = stk[sp];
        end
        else m_pc = m_pc + PC_STEP;
        wr(REG_INSTR, 32'(i));
        #1;
        while (BUSY === 1'b1 && n < 5) begin
            @(posedge SYS_CLK);
            #1;
            n++;
        end
        `CHK("busy_cycles", (p inside {OP_RET_LIT, OP_IRQ_RET}) ? 1 : 0, n)
        chk_all(f);
        rd(REG_INSTR, 32'(i));
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #200_000;
        n_errors++;
        $display("Error watchdog expected finish seen hang");
        results();
    end

    initial begin
        {m_acc, m_z, m_c, m_irq_en, m_pc, sp} = '0;
        foreach (m_f[j]) m_f[j] = 8'h00;
        foreach (stk[j]) stk[j] = '0;
        repeat (4) @(posedge SYS_CLK);
        RESET <= 1'b0;
        chk_all(7'd0);
        rd(12'h014, 32'h0, RESP_SLVERR, 3);
        wr(12'h014, 32'h5A, RESP_SLVERR, 3);
        // Low lane masked off: the 8-bit file register must keep its value
        wr(fa(7'd0), 32'hFF, RESP_OKAY, 0, 4'hE);
        chk_all(7'd0);
        $display("test reset_map done");
        for (int j = 0; j < FILES; j++) begin
            rv = $random(seed);
            m_f[j] = rv[7:0];
            wr(fa(7'(j)), rv);
        end
        wr(REG_STATUS, 32'h2);
        m_c = 1'b1;
        $display("test load_files done");
        wr(fa(7'd5), 32'hFF);
        m_f[5] = 8'hFF;
        op(OP_INC, 1'b1, 7'd5, 8'h00);
        op(OP_COPY, 1'b1, 7'd5, 8'h00);
        op(OP_ROT_L, 1'b0, 7'd127, 8'h00);
        push(13'h1ABC);
        op(OP_RET_LIT, 1'b0, 7'd0, 8'hFF);
        $display("test directed done");
        repeat (64) begin
            rv = $random(seed);
            o = op_e'(4'(rv[7:0] % 9));
            if (o inside {OP_RET_LIT, OP_IRQ_RET}) push(rv[28:16]);
            op(o, rv[8], rv[15:9], rv[31:24]);
        end
        $display("test random done");
        results();
    end
endmodule

`default_nettype wire
